// ==== aicfg_seq.sv ====
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
// How it works
// - bridge target select written 0x18 first
// - bridge index register loaded next
// - byte count one or two
// - payload written after count
// - command 0x02 written last, launches transfer
// - soft reset after boot start, then 20 ms wait
// - four internal trims in fixed order
// - volume ramp skipped before volume
// - two-byte 0 dB volume
// - speaker gain after volume
// - processor active, then processor on
// - amplifier on as final step
// - amplifier-on byte selects PWM rate
module aicfg_seq #(
    parameter int unsigned RESET_WAIT_CYC = aicfg_pkg::RESET_WAIT_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic dev_valid,
    output logic [15:0] dev_addr,
    output logic [2:0] dev_size,
    output logic [31:0] dev_data,
    input wire logic dev_ack
);

    typedef struct packed {
        aicfg_pkg::aicfg_state_t st;
        logic [3:0] op;
        logic [2:0] sub;
        logic [aicfg_pkg::CNT_W-1:0] cnt;
        logic req;
        logic done;
        logic [1:0] pwm;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } aicfg_top_s_t;

    aicfg_top_s_t q;
    aicfg_top_s_t d;
    aicfg_wr_if wr ();
    aicfg_pkg::aicfg_op_t cur;

    // ****************************************
    // sequence table
    // ****************************************
    function automatic aicfg_pkg::aicfg_op_t op_entry(input logic [3:0] op, input logic [1:0] pwm);
        aicfg_pkg::aicfg_op_t e;
        e = '{bridged: 1'b1, idx: 8'h00, len: aicfg_pkg::SIZE_1, val: 32'h0000_0000};
        case (op)
            aicfg_pkg::OP_BOOT: begin
                e = '{1'b0, 8'h00, aicfg_pkg::SIZE_1, aicfg_pkg::BOOT_VAL};
            end
            aicfg_pkg::OP_SOFT_RESET: begin
                e = '{1'b1, aicfg_pkg::AMP_SOFT_RESET_IDX, aicfg_pkg::SIZE_1,
                      aicfg_pkg::AMP_SOFT_RESET_VAL};
            end
            4'h2: e = '{1'b1, aicfg_pkg::AMP_TRIM0_IDX, aicfg_pkg::SIZE_1, aicfg_pkg::AMP_TRIM0_VAL};
            4'h3: e = '{1'b1, aicfg_pkg::AMP_TRIM1_IDX, aicfg_pkg::SIZE_1, aicfg_pkg::AMP_TRIM1_VAL};
            4'h4: e = '{1'b1, aicfg_pkg::AMP_TRIM2_IDX, aicfg_pkg::SIZE_1, aicfg_pkg::AMP_TRIM2_VAL};
            4'h5: e = '{1'b1, aicfg_pkg::AMP_TRIM3_IDX, aicfg_pkg::SIZE_1, aicfg_pkg::AMP_TRIM3_VAL};
            4'h6: begin
                e = '{1'b1, aicfg_pkg::AMP_RAMP_IDX, aicfg_pkg::SIZE_1,
                      aicfg_pkg::AMP_RAMP_SKIP_VAL};
            end
            4'h7: begin
                e = '{1'b1, aicfg_pkg::AMP_VOL_IDX, aicfg_pkg::SIZE_2,
                      aicfg_pkg::AMP_VOL_0DB_VAL};
            end
            4'h8: begin
                e = '{1'b1, aicfg_pkg::AMP_GAIN_IDX, aicfg_pkg::SIZE_1,
                      aicfg_pkg::AMP_SPEAKER_GAIN_VAL};
            end
            aicfg_pkg::OP_PROC_ACTIVE: begin
                e = '{1'b0, 8'h00, aicfg_pkg::SIZE_4, aicfg_pkg::PROC_ACTIVE_VAL};
            end
            aicfg_pkg::OP_PROC_ON: begin
                e = '{1'b0, 8'h00, aicfg_pkg::SIZE_4, aicfg_pkg::PROC_ON_VAL};
            end
            aicfg_pkg::OP_AMP_ON: begin
                e = '{1'b1, aicfg_pkg::AMP_ON_IDX, aicfg_pkg::SIZE_1, aicfg_pkg::AMP_ON_1M5};
                if (pwm == aicfg_pkg::PWM_384K) begin
                    e.val = aicfg_pkg::AMP_ON_384K;
                end else if (pwm == aicfg_pkg::PWM_768K) begin
                    e.val = aicfg_pkg::AMP_ON_768K;
                end
            end
            default: e.bridged = 1'b1;
        endcase
        return e;
    endfunction : op_entry

    function automatic logic reg_hit(input logic [3:0] a);
        return (a[3:2] == aicfg_pkg::CTRL_WORD) || (a[3:2] == aicfg_pkg::STAT_WORD);
    endfunction : reg_hit

    assign cur = op_entry(q.op, q.pwm);

    // ****************************************
    // device write request
    // ****************************************
    always_comb begin
        wr.size = aicfg_pkg::SIZE_1;
        wr.addr = aicfg_pkg::BRG_TGT_ADDR;
        wr.data = aicfg_pkg::BRG_TGT_AMP;
        if (!cur.bridged) begin
            wr.addr = (q.op == aicfg_pkg::OP_BOOT) ? aicfg_pkg::BOOT_ADDR
                                                   : aicfg_pkg::PROC_RUN_ADDR;
            wr.size = cur.len;
            wr.data = cur.val;
        end else begin
            case (q.sub)
                aicfg_pkg::SUB_INDEX: begin
                    wr.addr = aicfg_pkg::BRG_INDEX_ADDR;
                    wr.data = {24'h000000, cur.idx};
                end
                aicfg_pkg::SUB_LEN: begin
                    wr.addr = aicfg_pkg::BRG_LEN_ADDR;
                    wr.data = {29'h00000000, cur.len};
                end
                aicfg_pkg::SUB_PAY: begin
                    wr.addr = aicfg_pkg::BRG_PAY_ADDR;
                    wr.size = cur.len;
                    wr.data = cur.val;
                end
                aicfg_pkg::SUB_CMD: begin
                    wr.addr = aicfg_pkg::BRG_CMD_ADDR;
                    wr.data = aicfg_pkg::BRG_CMD_WRITE;
                end
                default: wr.addr = aicfg_pkg::BRG_TGT_ADDR;
            endcase
        end
    end
    assign wr.req = q.req;

    aicfg_port u_port (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr(wr),
        .dev_valid(dev_valid),
        .dev_addr(dev_addr),
        .dev_size(dev_size),
        .dev_data(dev_data),
        .dev_ack(dev_ack)
    );

    // ****************************************
    // sequencer and register slave
    // ****************************************
    always_comb begin
        d = q;
        case (q.st)
            aicfg_pkg::ST_IDLE: begin
                if (q.awready && awaddr[3:2] == aicfg_pkg::CTRL_WORD && wstrb[0]
                    && wdata[aicfg_pkg::CTRL_START_BIT]) begin
                    d.op = aicfg_pkg::OP_BOOT;
                    d.sub = aicfg_pkg::SUB_TGT;
                    d.req = 1'b1;
                    d.done = 1'b0;
                    d.st = aicfg_pkg::ST_ISSUE;
                end
                if (q.awready && awaddr[3:2] == aicfg_pkg::CTRL_WORD && wstrb[0]) begin
                    d.pwm = wdata[aicfg_pkg::CTRL_PWM_LSB +: 2];
                end
            end
            aicfg_pkg::ST_ISSUE: begin
                if (wr.done) begin
                    if (cur.bridged && q.sub != aicfg_pkg::SUB_CMD) begin
                        d.sub = q.sub + 3'h1;
                    end else begin
                        d.sub = aicfg_pkg::SUB_TGT;
                        if (q.op == aicfg_pkg::OP_SOFT_RESET) begin
                            d.req = 1'b0;
                            d.cnt = '0;
                            d.st = aicfg_pkg::ST_WAIT;
                        end else if (q.op == aicfg_pkg::OP_AMP_ON) begin
                            d.req = 1'b0;
                            d.done = 1'b1;
                            d.st = aicfg_pkg::ST_IDLE;
                        end else begin
                            d.op = q.op + 4'h1;
                        end
                    end
                end
            end
            aicfg_pkg::ST_WAIT: begin
                d.cnt = q.cnt + 1'b1;
                if (q.cnt == aicfg_pkg::CNT_W'(RESET_WAIT_CYC - 1)) begin
                    d.op = q.op + 4'h1;
                    d.req = 1'b1;
                    d.st = aicfg_pkg::ST_ISSUE;
                end
            end
            default: d.st = aicfg_pkg::ST_IDLE;
        endcase

        if (!q.awready && !q.bvalid && awvalid && wvalid) begin
            d.awready = 1'b1;
            d.wready = 1'b1;
        end
        if (q.awready) begin
            d.awready = 1'b0;
            d.wready = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = reg_hit(awaddr) ? aicfg_pkg::RESP_OKAY : aicfg_pkg::RESP_SLVERR;
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end

        if (!q.arready && !q.rvalid && arvalid) begin
            d.arready = 1'b1;
        end
        if (q.arready) begin
            d.arready = 1'b0;
            d.rvalid = 1'b1;
            d.rresp = reg_hit(araddr) ? aicfg_pkg::RESP_OKAY : aicfg_pkg::RESP_SLVERR;
            d.rdata = '0;
            if (araddr[3:2] == aicfg_pkg::CTRL_WORD) begin
                d.rdata[aicfg_pkg::CTRL_PWM_LSB +: 2] = q.pwm;
            end else if (araddr[3:2] == aicfg_pkg::STAT_WORD) begin
                d.rdata[aicfg_pkg::STAT_BUSY_BIT] = (q.st != aicfg_pkg::ST_IDLE);
                d.rdata[aicfg_pkg::STAT_DONE_BIT] = q.done;
                d.rdata[aicfg_pkg::STAT_WAIT_BIT] = (q.st == aicfg_pkg::ST_WAIT);
                d.rdata[aicfg_pkg::STAT_OP_LSB +: 4] = q.op;
                d.rdata[aicfg_pkg::STAT_SUB_LSB +: 3] = q.sub;
            end
        end
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '{st: aicfg_pkg::ST_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;

    // ****************************************
    // checks on the device write stream
    // ****************************************
    logic fire;
    logic first_q;
    logic gap_on_q;
    logic [15:0] last_addr_q;
    logic [31:0] last_data_q;
    logic [7:0] idx_q;
    logic [aicfg_pkg::CNT_W-1:0] gap_q;

    assign fire = dev_valid && dev_ack;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_q <= 1'b1;
            gap_on_q <= 1'b0;
            last_addr_q <= '0;
            last_data_q <= '0;
            idx_q <= '0;
            gap_q <= '0;
        end else begin
            gap_q <= gap_q + 1'b1;
            if (q.st == aicfg_pkg::ST_IDLE) begin
                first_q <= 1'b1;
            end
            if (fire) begin
                first_q <= 1'b0;
                last_addr_q <= dev_addr;
                last_data_q <= dev_data;
                gap_on_q <= (dev_addr == aicfg_pkg::BRG_CMD_ADDR)
                            && (idx_q == aicfg_pkg::AMP_SOFT_RESET_IDX);
                gap_q <= '0;
                if (dev_addr == aicfg_pkg::BRG_INDEX_ADDR) begin
                    idx_q <= dev_data[7:0];
                end
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_reset_cmd;
        fire && dev_addr == aicfg_pkg::BRG_CMD_ADDR && idx_q == aicfg_pkg::AMP_SOFT_RESET_IDX;
    endsequence
    sequence s_on_cmd;
        fire && dev_addr == aicfg_pkg::BRG_CMD_ADDR && idx_q == aicfg_pkg::AMP_ON_IDX;
    endsequence

    boot_first_a: assert property (fire && first_q |->
        dev_addr == aicfg_pkg::BOOT_ADDR && dev_data == aicfg_pkg::BOOT_VAL)
        else $error("first write is not boot start");
    target_sel_a: assert property (fire && dev_addr == aicfg_pkg::BRG_INDEX_ADDR |->
        last_addr_q == aicfg_pkg::BRG_TGT_ADDR && last_data_q == aicfg_pkg::BRG_TGT_AMP)
        else $error("index written without target select");
    len_order_a: assert property (fire && dev_addr == aicfg_pkg::BRG_LEN_ADDR |->
        last_addr_q == aicfg_pkg::BRG_INDEX_ADDR)
        else $error("length written before index");
    len_value_a: assert property (fire && dev_addr == aicfg_pkg::BRG_LEN_ADDR |->
        dev_data == 32'h0000_0001 || dev_data == 32'h0000_0002)
        else $error("bad byte count");
    payload_size_a: assert property (fire && dev_addr == aicfg_pkg::BRG_PAY_ADDR |->
        last_addr_q == aicfg_pkg::BRG_LEN_ADDR && dev_size == last_data_q[2:0])
        else $error("payload size does not match count");
    launch_cmd_a: assert property (fire && dev_addr == aicfg_pkg::BRG_CMD_ADDR |->
        dev_data == aicfg_pkg::BRG_CMD_WRITE && last_addr_q == aicfg_pkg::BRG_PAY_ADDR)
        else $error("bad bridge launch");
    reset_quiet_a: assert property (s_reset_cmd |=> !dev_valid [*8])
        else $error("write issued right after soft reset");
    reset_gap_a: assert property (fire && gap_on_q |-> gap_q >= RESET_WAIT_CYC - 1)
        else $error("soft reset wait too short");
    proc_order_a: assert property (fire && dev_data == aicfg_pkg::PROC_ON_VAL |->
        last_data_q == aicfg_pkg::PROC_ACTIVE_VAL)
        else $error("processor on before active");
    pwm_byte_a: assert property (fire && dev_addr == aicfg_pkg::BRG_PAY_ADDR
        && idx_q == aicfg_pkg::AMP_ON_IDX |-> dev_data == op_entry(aicfg_pkg::OP_AMP_ON, q.pwm).val)
        else $error("amplifier-on byte does not match PWM choice");
    final_step_a: assert property (s_on_cmd |-> ##[1:3] (q.st == aicfg_pkg::ST_IDLE && q.done))
        else $error("sequence did not end after amplifier on");

endmodule : aicfg_seq

// ==== aicfg_pkg.sv ====
package aicfg_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned RESET_WAIT_MS = 20;
    localparam int unsigned RESET_WAIT_CYC = RESET_WAIT_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W = 24;

    // ****************************************
    // device register map
    // ****************************************
    localparam logic [15:0] PROC_RUN_ADDR = 16'h0000;
    localparam logic [15:0] BOOT_ADDR = 16'hFF01;
    localparam logic [15:0] BRG_INDEX_ADDR = 16'hFF40;
    localparam logic [15:0] BRG_LEN_ADDR = 16'hFF41;
    localparam logic [15:0] BRG_PAY_ADDR = 16'hFF42;
    localparam logic [15:0] BRG_CMD_ADDR = 16'hFF43;
    localparam logic [15:0] BRG_TGT_ADDR = 16'hFF45;

    localparam logic [31:0] BOOT_VAL = 32'h0000_0001;
    localparam logic [31:0] BRG_TGT_AMP = 32'h0000_0018;
    localparam logic [31:0] BRG_CMD_WRITE = 32'h0000_0002;
    localparam logic [31:0] PROC_ACTIVE_VAL = 32'h0203_7800;
    localparam logic [31:0] PROC_ON_VAL = 32'h0603_7800;

    localparam logic [2:0] SIZE_1 = 3'h1;
    localparam logic [2:0] SIZE_2 = 3'h2;
    localparam logic [2:0] SIZE_4 = 3'h4;

    // ****************************************
    // amplifier registers behind the bridge
    // ****************************************
    localparam logic [7:0] AMP_SOFT_RESET_IDX = 8'h40;
    localparam logic [31:0] AMP_SOFT_RESET_VAL = 32'h0000_0080;
    localparam logic [7:0] AMP_TRIM0_IDX = 8'h63;
    localparam logic [31:0] AMP_TRIM0_VAL = 32'h0000_00DE;
    localparam logic [7:0] AMP_TRIM1_IDX = 8'h65;
    localparam logic [31:0] AMP_TRIM1_VAL = 32'h0000_0066;
    localparam logic [7:0] AMP_TRIM2_IDX = 8'h15;
    localparam logic [31:0] AMP_TRIM2_VAL = 32'h0000_0020;
    localparam logic [7:0] AMP_TRIM3_IDX = 8'h6E;
    localparam logic [31:0] AMP_TRIM3_VAL = 32'h0000_0019;
    localparam logic [7:0] AMP_RAMP_IDX = 8'h0A;
    localparam logic [31:0] AMP_RAMP_SKIP_VAL = 32'h0000_0009;
    localparam logic [7:0] AMP_VOL_IDX = 8'h20;
    localparam logic [31:0] AMP_VOL_0DB_VAL = 32'h0000_0180;
    localparam logic [7:0] AMP_GAIN_IDX = 8'h07;
    localparam logic [31:0] AMP_SPEAKER_GAIN_VAL = 32'h0000_0037;
    localparam logic [7:0] AMP_ON_IDX = 8'h05;
    localparam logic [31:0] AMP_ON_384K = 32'h0000_0080;
    localparam logic [31:0] AMP_ON_768K = 32'h0000_0084;
    localparam logic [31:0] AMP_ON_1M5 = 32'h0000_008C;

    // ****************************************
    // sequence steps
    // ****************************************
    localparam logic [3:0] OP_BOOT = 4'h0;
    localparam logic [3:0] OP_SOFT_RESET = 4'h1;
    localparam logic [3:0] OP_PROC_ACTIVE = 4'h9;
    localparam logic [3:0] OP_PROC_ON = 4'hA;
    localparam logic [3:0] OP_AMP_ON = 4'hB;
    localparam logic [2:0] SUB_TGT = 3'h0;
    localparam logic [2:0] SUB_INDEX = 3'h1;
    localparam logic [2:0] SUB_LEN = 3'h2;
    localparam logic [2:0] SUB_PAY = 3'h3;
    localparam logic [2:0] SUB_CMD = 3'h4;

    // ****************************************
    // own register file
    // ****************************************
    localparam logic [1:0] CTRL_WORD = 2'h0;
    localparam logic [1:0] STAT_WORD = 2'h1;
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_PWM_LSB = 1;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_DONE_BIT = 1;
    localparam int unsigned STAT_WAIT_BIT = 2;
    localparam int unsigned STAT_OP_LSB = 8;
    localparam int unsigned STAT_SUB_LSB = 12;
    localparam logic [1:0] PWM_384K = 2'h0;
    localparam logic [1:0] PWM_768K = 2'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_WAIT
    } aicfg_state_t;

    typedef struct packed {
        logic bridged;
        logic [7:0] idx;
        logic [2:0] len;
        logic [31:0] val;
    } aicfg_op_t;

endpackage : aicfg_pkg

// ==== aicfg_wr_if.sv ====
`timescale 1ns/10ps
interface aicfg_wr_if;
    logic req;
    logic [15:0] addr;
    logic [2:0] size;
    logic [31:0] data;
    logic done;

    modport seq (output req, output addr, output size, output data, input done);
    modport port (input req, input addr, input size, input data, output done);
endinterface : aicfg_wr_if

// ==== aicfg_port.sv ====
`timescale 1ns/10ps
module aicfg_port (
    input wire logic aclk,
    input wire logic aresetn,
    aicfg_wr_if.port wr,
    output logic dev_valid,
    output logic [15:0] dev_addr,
    output logic [2:0] dev_size,
    output logic [31:0] dev_data,
    input wire logic dev_ack
);

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [2:0] size;
        logic [31:0] data;
        logic done;
    } aicfg_port_s_t;

    aicfg_port_s_t q;
    aicfg_port_s_t d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        // done cycle blocks a relatch of the old request
        if (!q.valid && !q.done && wr.req) begin
            d.valid = 1'b1;
            d.addr = wr.addr;
            d.size = wr.size;
            d.data = wr.data;
        end
        if (q.valid && dev_ack) begin
            d.valid = 1'b0;
            d.done = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dev_valid = q.valid;
    assign dev_addr = q.addr;
    assign dev_size = q.size;
    assign dev_data = q.data;
    assign wr.done = q.done;

endmodule : aicfg_port

// ==== aicfg_dev_model.sv ====
`timescale 1ns/10ps
// ****************************************
// device side: register writes with varying ack delay
// ****************************************
module aicfg_dev_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic dev_valid,
    input wire logic [15:0] dev_addr,
    input wire logic [2:0] dev_size,
    input wire logic [31:0] dev_data,
    output logic dev_ack
);
    logic [50:0] log_q[$];
    int stamp_q[$];
    int cyc = 0;
    logic [1:0] dly = 2'h0;
    logic [1:0] wt = 2'h0;
    logic [7:0] idx = 8'h00;
    logic [31:0] pay = 32'h0000_0000;
    logic [31:0] amp [0:255];
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (!aresetn) begin
            dev_ack <= 1'b0;
            wt <= 2'h0;
        end else if (dev_valid && dev_ack) begin
            dev_ack <= 1'b0;
            wt <= 2'h0;
            dly <= dly + 2'h1;
            log_q.push_back({dev_addr, dev_size, dev_data});
            stamp_q.push_back(cyc);
            if (dev_addr == 16'hFF40) idx <= dev_data[7:0];
            if (dev_addr == 16'hFF42) pay <= dev_data;
            if (dev_addr == 16'hFF43 && dev_data == 32'h0000_0002) amp[idx] <= pay;
        end else if (dev_valid) begin
            if (wt >= dly) dev_ack <= 1'b1;
            wt <= wt + 2'h1;
        end else begin
            dev_ack <= 1'b0;
        end
    end
endmodule : aicfg_dev_model

// ==== amp_init_config_sequencer_test.sv ====
`timescale 1ns/10ps
module amp_init_config_sequencer_test;
    localparam int WAIT_CYC = 20;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid, dev_valid, dev_ack;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, dev_data, rd;
    logic [15:0] dev_addr;
    logic [2:0] dev_size;
    logic [50:0] exp_q[$];
    int n_errors = 0;
    int checks_done = 0;

    aicfg_seq #(.RESET_WAIT_CYC(WAIT_CYC)) DUT (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .dev_valid(dev_valid), .dev_addr(dev_addr),
        .dev_size(dev_size), .dev_data(dev_data), .dev_ack(dev_ack));
    aicfg_dev_model dev_model (.aclk(aclk), .aresetn(aresetn), .dev_valid(dev_valid),
        .dev_addr(dev_addr), .dev_size(dev_size), .dev_data(dev_data), .dev_ack(dev_ack));

    initial forever #25 aclk = ~aclk;

    // ****************************************
    // bus tasks
    // ****************************************
    task automatic chk(input string what, input logic [50:0] e, input logic [50:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axr

    task automatic eb(input logic [7:0] i, input logic [2:0] n, input logic [31:0] v);
        exp_q.push_back({16'hFF45, 3'h1, 32'h0000_0018});
        exp_q.push_back({16'hFF40, 3'h1, 24'h00_0000, i});
        exp_q.push_back({16'hFF41, 3'h1, 29'h0000_0000, n});
        exp_q.push_back({16'hFF42, n, v});
        exp_q.push_back({16'hFF43, 3'h1, 32'h0000_0002});
    endtask : eb

    // ****************************************
    // tests
    // ****************************************
    task automatic run(input logic [1:0] pwm, input logic [7:0] on);
        int t;
        logic [2:0] seen;
        exp_q.delete();
        dev_model.amp[8'h05] = 32'h0000_0000;
        dev_model.log_q.delete();
        dev_model.stamp_q.delete();
        exp_q.push_back({16'hFF01, 3'h1, 32'h0000_0001});
        eb(8'h40, 3'h1, 32'h0000_0080);
        eb(8'h63, 3'h1, 32'h0000_00DE);
        eb(8'h65, 3'h1, 32'h0000_0066);
        eb(8'h15, 3'h1, 32'h0000_0020);
        eb(8'h6E, 3'h1, 32'h0000_0019);
        eb(8'h0A, 3'h1, 32'h0000_0009);
        eb(8'h20, 3'h2, 32'h0000_0180);
        eb(8'h07, 3'h1, 32'h0000_0037);
        exp_q.push_back({16'h0000, 3'h4, 32'h0203_7800});
        exp_q.push_back({16'h0000, 3'h4, 32'h0603_7800});
        eb(8'h05, 3'h1, {24'h00_0000, on});
        axw(4'h0, {29'h0000_0000, pwm, 1'b1}, resp);
        chk("start resp", 51'h0, resp);
        axw(4'h0, 32'h0000_0001, resp);
        chk("busy start resp", 51'h0, resp);
        t = 0;
        seen = 3'h0;
        do begin
            axr(4'h4, rd, resp);
            seen = seen | rd[2:0];
            t++;
        end while (rd[1] !== 1'b1 && t < 2000);
        chk("status flags", 51'h0B02, rd);
        chk("status bits seen", 51'h7, seen);
        axr(4'h0, rd, resp);
        chk("ctrl pwm", pwm, rd[2:1]);
        chk("write count", 51'd48, dev_model.log_q.size());
        for (int k = 0; k < exp_q.size() && k < dev_model.log_q.size(); k++) begin
            chk($sformatf("dev write %0d", k), exp_q[k], dev_model.log_q[k]);
        end
        if (dev_model.stamp_q.size() > 6) begin
            chk("reset wait", 51'h1, (dev_model.stamp_q[6] - dev_model.stamp_q[5]) >= WAIT_CYC);
        end
        chk("amp on byte", {43'h0, on}, dev_model.amp[8'h05]);
        $display("test pwm %0d finished", pwm);
    endtask : run

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (40000) @(posedge aclk);
        n_errors++;
        results();
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axr(4'h4, rd, resp);
        chk("status after reset", 51'h0, {resp, rd});
        axr(4'h8, rd, resp);
        chk("unmapped read", 51'h2_0000_0000, {resp, rd});
        axw(4'hC, 32'h0000_0001, resp);
        chk("unmapped write", 51'h2, resp);
        axw(4'h4, 32'h0000_0001, resp);
        chk("status write resp", 51'h0, resp);
        wstrb <= 4'hE;
        axw(4'h0, 32'h0000_0001, resp);
        chk("masked start resp", 51'h0, resp);
        wstrb <= 4'hF;
        axr(4'h4, rd, resp);
        chk("status write ignored", 51'h0, rd);
        $display("test registers finished");
        run(2'h0, 8'h80);
        run(2'h1, 8'h84);
        run(2'h2, 8'h8C);
        run(2'h3, 8'h8C);
        results();
    end
endmodule : amp_init_config_sequencer_test
